// ---- testbench/cssc_osc_model.sv ----
// Behavioural watchdog oscillator and selected clock source.
`timescale 1ns/1ps
module cssc_osc_model (
  input wire logic clk_i,
  output logic wdt_osc_o,
  output logic sel_osc_o
);
  // Both oscillators stand still between bursts, so every edge is counted
  initial begin
    wdt_osc_o = 1'b0;
    sel_osc_o = 1'b0;
  end

  // Slow enough that every edge gets through the pin synchronisers
  task automatic burst(input bit wdt, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      wdt_osc_o <= wdt;
      sel_osc_o <= !wdt;
      repeat (4) @(posedge clk_i);
      wdt_osc_o <= 1'b0;
      sel_osc_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
endmodule // cssc_osc_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the clock source and start-up controller.
`timescale 1ns/1ps
module testbench;
  localparam int NC = 10;
  localparam logic [3:0] SEL [NC] = '{4'h2, 4'hF, 4'h8, 4'h7, 4'h5,
    4'h3, 4'h1, 4'h0, 4'hA, 4'hD};
  localparam logic [1:0] STIME [NC] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h2,
    2'h0, 2'h3, 2'h1, 2'h3, 2'h1};
  localparam logic [2:0] SRC [NC] = '{3'h4, 3'h0, 3'h0, 3'h1, 3'h2,
    3'h3, 3'h4, 3'h5, 3'h0, 3'h0};
  localparam logic [2:0] AMP [NC] = '{3'h0, 3'h7, 3'h4, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h5, 3'h6};
  // Watchdog edges, long count cut to 16; zero where the fuses select no time-out
  localparam logic [15:0] TOUT [NC] = '{16'h0010, 16'h0000, 16'h0200,
    16'h0010, 16'h0010, 16'h0000, 16'h0010, 16'h0200, 16'h0200, 16'h0000};
  // Stabilisation plus extra edges; 16K cut to 20, 32K cut to 24
  localparam logic [15:0] STAB [NC] = '{16'h0014, 16'h0022, 16'h0110,
    16'h040E, 16'h001C, 16'h0014, 16'h0014, 16'h0014, 16'h040E, 16'h0022};
  localparam logic [5:0] EN_SLP [5] = '{6'h16, 6'h07, 6'h01, 6'h05, 6'h01};

  logic clk, rst, div_f, rsrc, sleep, wake, lvl;
  logic [3:0] sel_f;
  logic [1:0] stime_f, mode;
  logic int_rst, core_en, per_en, mem_en, asy_en, cnv_en, det_en, tick;
  logic [2:0] src, amp;
  logic div8, res, irq, wdt_osc, sel_osc;
  int num_errors = 0;
  int samples_checked = 0;
  int ticks = 0;
  int irqs = 0;
  wire [5:0] en = {core_en, per_en, mem_en, asy_en, cnv_en, det_en};

  cssc_top #(.TOUT_LONG_CYC(16'h0010), .STAB_16K_CYC(16'h0014),
    .STAB_32K_CYC(16'h0018)) u_dut (
    .CORE_CLK_I(clk), .RST_I(rst), .SOURCE_SELECT_FUSES_I(sel_f),
    .STARTUP_TIME_FUSES_I(stime_f), .DIVIDE_BY_EIGHT_FUSE_I(div_f),
    .RESET_SOURCES_I(rsrc), .WDT_OSC_I(wdt_osc), .SEL_OSC_I(sel_osc),
    .SLEEP_I(sleep), .SLEEP_MODE_I(mode), .WAKE_I(wake),
    .LEVEL_IRQ_I(lvl), .INTERNAL_RESET_O(int_rst),
    .CORE_CLOCK_EN_O(core_en), .PERIPHERAL_CLOCK_EN_O(per_en),
    .PROGRAM_MEMORY_CLOCK_EN_O(mem_en), .ASYNC_TIMER_CLOCK_EN_O(asy_en),
    .CONVERTER_CLOCK_EN_O(cnv_en), .ASYNC_DETECT_EN_O(det_en),
    .SYS_CLK_TICK_O(tick), .CLK_SOURCE_O(src), .AMP_RANGE_O(amp),
    .DIV8_ACTIVE_O(div8), .FUSE_RESERVED_O(res), .LEVEL_IRQ_O(irq));

  cssc_osc_model u_osc (.clk_i(clk), .wdt_osc_o(wdt_osc),
    .sel_osc_o(sel_osc));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tick === 1'b1) ticks++;
    if (irq === 1'b1) irqs++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic start_up(input int i);
    sel_f <= SEL[i];
    stime_f <= STIME[i];
    div_f <= i[0];
    rst <= 1'b1;
    rsrc <= 1'b1;
    cyc(2);
    chk(16'(src), 16'h0004);
    chk(16'(div8), 16'h0001);
    rst <= 1'b0;
    cyc(6);
    rsrc <= 1'b0;
    cyc(6);
    chk(16'(src), 16'(SRC[i]));
    chk(16'(amp), 16'(AMP[i]));
    chk(16'(div8), 16'(!i[0]));
    chk(16'(res), 16'(i == 6));
    if (TOUT[i] != 16'h0000) begin
      u_osc.burst(1'b1, TOUT[i] - 1);
      // Source edges during the time-out must not count
      u_osc.burst(1'b0, 3);
      chk(16'(int_rst), 16'h0001);
      u_osc.burst(1'b1, 1);
    end
    cyc(4);
    @(negedge clk);
    ticks = 0;
    u_osc.burst(1'b0, STAB[i] - 1);
    cyc(4);
    chk(16'(int_rst), 16'h0001);
    chk(16'(ticks), 16'h0000);
    u_osc.burst(1'b0, 1);
    cyc(2);
    chk(16'(int_rst), 16'h0000);
    chk(16'(en), 16'h003E);
    @(negedge clk);
    ticks = 0;
    u_osc.burst(1'b0, 16);
    cyc(4);
    chk(16'(ticks), i[0] ? 16'h0010 : 16'h0002);
    sel_f <= ~SEL[i];
    div_f <= !i[0];
    cyc(8);
    chk(16'(src), 16'(SRC[i]));
    chk(16'(div8), 16'(!i[0]));
  endtask

  initial begin
    rst = 1'b1;
    rsrc = 1'b1;
    sel_f = 4'h2;
    stime_f = 2'h2;
    div_f = 1'b0;
    sleep = 1'b0;
    mode = 2'h0;
    wake = 1'b0;
    lvl = 1'b0;
    cyc(2);
    for (int i = 0; i < NC; i++) start_up(i);
    // Last case runs a 16K-class source: wake counts 20 edges, no extra
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      irqs = 0;
      cyc(1);
      mode <= (i == 4) ? 2'h2 : 2'(i);
      sleep <= 1'b1;
      lvl <= 1'b1;
      cyc(1);
      sleep <= 1'b0;
      cyc(3);
      chk(16'(en), 16'(EN_SLP[i]));
      wake <= 1'b1;
      if (i >= 2) begin
        cyc(4);
        u_osc.burst(1'b0, 10);
        // Last pass lets the level go before start-up ends
        lvl <= (i != 4);
        u_osc.burst(1'b0, 9);
        cyc(4);
        chk(16'(core_en), 16'h0000);
        u_osc.burst(1'b0, 1);
      end
      cyc(6);
      wake <= 1'b0;
      lvl <= 1'b0;
      chk(16'(en), 16'h003E);
      chk(16'(irqs), 16'(i == 2));
    end
    summarize();
  end

  initial begin
    cyc(60000);
    num_errors++;
    summarize();
  end
endmodule // testbench

// ---- verilog/cssc_pkg.sv ----
// Constants and types shared by the clock source and start-up controller.
// Overview of operation
// - Decode four fuse bits into low-power, full-swing, low-frequency, RC or external source.
// - A fuse bit reading one is unprogrammed; reading zero is programmed.
// - Default is calibrated RC, slowest start-up, time-out on, divide-by-eight on.
// - Internal reset is held for a time-out after other reset sources release.
// - Time-out lengths are 0, 512 or 8192 watchdog oscillator cycles.
// - A counter on the chosen oscillator holds reset until enough cycles pass.
// - Reset start-up uses time-out then stabilisation; deep-sleep wake uses stabilisation only.
// - Stabilisation count depends on source, from 6 to 32K cycles.
// - In low-power crystal mode the upper three select bits give amplifier range.
// - Low-power crystal stabilisation is 258, 1K or 16K cycles by code.
// - Reset adds 14 cycles plus none, short or long time-out by code.
// - A programmed divide fuse divides the system clock by eight.
// - Sleep modes gate clocks of unused domains independently.
// - Gating the core clock stops all core operation.
// - Program memory clock follows the core clock.
// - Asynchronous timer clock keeps running during sleep, except in power-down where it stops.
// - Converter clock runs in noise-reduction sleep while core and peripheral clocks are gated.
// - Serial start and address detection stay active while peripheral clock is gated.
// - A level wake from power-down raises an interrupt only if the level outlasts start-up.
package cssc_pkg;

  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    SRC_LP_XTAL,
    SRC_FS_XTAL,
    SRC_LF_XTAL,
    SRC_RC128K,
    SRC_RC_CAL,
    SRC_EXT
  } cssc_src_t;

  typedef enum logic [1:0] {
    SLP_IDLE,
    SLP_ADC_NR,
    SLP_PWR_DOWN,
    SLP_PWR_SAVE
  } cssc_sleep_t;

  localparam logic [3:0] SRC_SEL_RESERVED = 4'h1;

  // Latched fuse values before the first sample
  localparam logic [3:0] FUSE_SRC_DFLT = 4'h2;
  localparam logic [1:0] FUSE_STIME_DFLT = 2'h2;
  localparam logic FUSE_DIV8_DFLT = 1'b0;

  // Fuse synchroniser settle time before the sample, in core cycles
  localparam logic [1:0] FUSE_WAIT_CYC = 2'h3;

  // Watchdog oscillator cycles of the supply time-out
  localparam logic [CNT_W-1:0] TOUT_NONE = 16'h0000;
  localparam logic [CNT_W-1:0] TOUT_SHORT = 16'h0200;
  localparam logic [CNT_W-1:0] TOUT_LONG_DFLT = 16'h2000;

  // Selected oscillator cycles of stabilisation
  localparam logic [CNT_W-1:0] STAB_258 = 16'h0102;
  localparam logic [CNT_W-1:0] STAB_1K = 16'h0400;
  localparam logic [CNT_W-1:0] STAB_16K_DFLT = 16'h4000;
  localparam logic [CNT_W-1:0] STAB_32K_DFLT = 16'h8000;
  localparam logic [CNT_W-1:0] STAB_EXT = 16'h0006;
  localparam logic [CNT_W-1:0] STAB_RC = 16'h0006;
  localparam logic [CNT_W-1:0] EXTRA_XTAL = 16'h000E;
  localparam logic [CNT_W-1:0] EXTRA_LF = 16'h0004;

  // Prescaler terminal count for divide by eight
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [2:0] DIV_ZERO = 3'h0;

endpackage

// ---- verilog/cssc_tick_counter.sv ----
// Synchronises an oscillator pin and counts its rising edges to a target.
`timescale 1ns/1ps
module cssc_tick_counter #(
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_pin_i,
  input wire logic clear_i,
  input wire logic [CNT_W-1:0] target_i,
  output logic tick_o,
  output logic done_o
);

  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic edge_det;

  // Only stages two and three feed the edge detector
  assign edge_det = sync_r[1] & ~sync_r[2];
  assign done_o = (cnt_r >= target_i);
  assign tick_o = tick_r;

  always_comb begin
    sync_nxt = {sync_r[1:0], tick_pin_i};
    tick_nxt = edge_det;
    cnt_nxt = cnt_r;
    if (clear_i) begin
      cnt_nxt = '0;
    end else if (edge_det && !done_o) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_r <= 3'h0;
      tick_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      sync_r <= sync_nxt;
      tick_r <= tick_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule // cssc_tick_counter

// ---- verilog/cssc_top.sv ----
// Clock source selection, start-up sequencing and clock domain gating.
`timescale 1ns/1ps
module cssc_top #(
  parameter logic [cssc_pkg::CNT_W-1:0] TOUT_LONG_CYC =
    cssc_pkg::TOUT_LONG_DFLT,
  parameter logic [cssc_pkg::CNT_W-1:0] STAB_16K_CYC =
    cssc_pkg::STAB_16K_DFLT,
  parameter logic [cssc_pkg::CNT_W-1:0] STAB_32K_CYC =
    cssc_pkg::STAB_32K_DFLT
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] SOURCE_SELECT_FUSES_I,
  input wire logic [1:0] STARTUP_TIME_FUSES_I,
  input wire logic DIVIDE_BY_EIGHT_FUSE_I,
  input wire logic RESET_SOURCES_I,
  input wire logic WDT_OSC_I,
  input wire logic SEL_OSC_I,
  input wire logic SLEEP_I,
  input wire logic [1:0] SLEEP_MODE_I,
  input wire logic WAKE_I,
  input wire logic LEVEL_IRQ_I,
  output logic INTERNAL_RESET_O,
  output logic CORE_CLOCK_EN_O,
  output logic PERIPHERAL_CLOCK_EN_O,
  output logic PROGRAM_MEMORY_CLOCK_EN_O,
  output logic ASYNC_TIMER_CLOCK_EN_O,
  output logic CONVERTER_CLOCK_EN_O,
  output logic ASYNC_DETECT_EN_O,
  output logic SYS_CLK_TICK_O,
  output logic [2:0] CLK_SOURCE_O,
  output logic [2:0] AMP_RANGE_O,
  output logic DIV8_ACTIVE_O,
  output logic FUSE_RESERVED_O,
  output logic LEVEL_IRQ_O
);

  localparam int CW = cssc_pkg::CNT_W;

  typedef enum logic [2:0] {
    ST_FUSE,
    ST_HOLD,
    ST_TOUT,
    ST_STAB,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } cssc_state_t;

  // Pin synchronisers: stage one is read only by stage two
  logic [9:0] pin_s1_r;
  logic [9:0] pin_s2_r;
  logic [9:0] pin_nxt;
  logic rst_src_s;
  logic wake_s;
  logic level_s;
  logic [3:0] src_sel_s;
  logic [1:0] stime_s;
  logic div8_s;

  assign pin_nxt = {LEVEL_IRQ_I, WAKE_I, RESET_SOURCES_I,
                    DIVIDE_BY_EIGHT_FUSE_I, STARTUP_TIME_FUSES_I,
                    SOURCE_SELECT_FUSES_I};
  assign src_sel_s = pin_s2_r[3:0];
  assign stime_s = pin_s2_r[5:4];
  assign div8_s = pin_s2_r[6];
  assign rst_src_s = pin_s2_r[7];
  assign wake_s = pin_s2_r[8];
  assign level_s = pin_s2_r[9];

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1_r <= 10'h000;
      pin_s2_r <= 10'h000;
    end else begin
      pin_s1_r <= pin_nxt;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Fuse latch and sequencer state
  cssc_state_t st_r;
  cssc_state_t st_nxt;
  logic [3:0] src_sel_r;
  logic [3:0] src_sel_nxt;
  logic [1:0] stime_r;
  logic [1:0] stime_nxt;
  logic div8_r;
  logic div8_nxt;
  logic latched_r;
  logic latched_nxt;
  logic [1:0] fwait_r;
  logic [1:0] fwait_nxt;
  cssc_pkg::cssc_sleep_t mode_r;
  cssc_pkg::cssc_sleep_t mode_nxt;
  logic irq_r;
  logic irq_nxt;

  // Decoded configuration
  cssc_pkg::cssc_src_t src;
  logic [CW-1:0] tout_tgt;
  logic [CW-1:0] stab_tgt;
  logic [CW-1:0] extra_tgt;
  logic [CW-1:0] osc_tgt;
  logic wdt_done;
  logic osc_done;
  logic osc_tick;
  logic [2:0] code;

  always_comb begin
    casez (src_sel_r)
      4'b1???: src = cssc_pkg::SRC_LP_XTAL;
      4'b011?: src = cssc_pkg::SRC_FS_XTAL;
      4'b010?: src = cssc_pkg::SRC_LF_XTAL;
      4'h3: src = cssc_pkg::SRC_RC128K;
      4'h2: src = cssc_pkg::SRC_RC_CAL;
      4'h0: src = cssc_pkg::SRC_EXT;
      default: src = cssc_pkg::SRC_RC_CAL;
    endcase
  end

  assign code = {src_sel_r[0], stime_r};

  always_comb begin
    tout_tgt = TOUT_LONG_CYC;
    stab_tgt = cssc_pkg::STAB_RC;
    extra_tgt = cssc_pkg::EXTRA_XTAL;
    case (src)
      cssc_pkg::SRC_LP_XTAL, cssc_pkg::SRC_FS_XTAL: begin
        case (code)
          3'h0: begin
            stab_tgt = cssc_pkg::STAB_258;
            tout_tgt = cssc_pkg::TOUT_SHORT;
          end
          3'h1: begin
            stab_tgt = cssc_pkg::STAB_258;
            tout_tgt = TOUT_LONG_CYC;
          end
          3'h2: begin
            stab_tgt = cssc_pkg::STAB_1K;
            tout_tgt = cssc_pkg::TOUT_NONE;
          end
          3'h3: begin
            stab_tgt = cssc_pkg::STAB_1K;
            tout_tgt = cssc_pkg::TOUT_SHORT;
          end
          3'h4: begin
            stab_tgt = cssc_pkg::STAB_1K;
            tout_tgt = TOUT_LONG_CYC;
          end
          3'h5: begin
            stab_tgt = STAB_16K_CYC;
            tout_tgt = cssc_pkg::TOUT_NONE;
          end
          3'h6: begin
            stab_tgt = STAB_16K_CYC;
            tout_tgt = cssc_pkg::TOUT_SHORT;
          end
          default: begin
            stab_tgt = STAB_16K_CYC;
            tout_tgt = TOUT_LONG_CYC;
          end
        endcase
      end
      default: begin
        // Shared time-out code for the other sources; 11 treated as longest
        case (stime_r)
          2'h0: tout_tgt = cssc_pkg::TOUT_NONE;
          2'h1: tout_tgt = cssc_pkg::TOUT_SHORT;
          default: tout_tgt = TOUT_LONG_CYC;
        endcase
        if (src == cssc_pkg::SRC_LF_XTAL) begin
          stab_tgt = src_sel_r[0] ? STAB_32K_CYC : cssc_pkg::STAB_1K;
          extra_tgt = cssc_pkg::EXTRA_LF;
        end else if (src == cssc_pkg::SRC_EXT) begin
          stab_tgt = cssc_pkg::STAB_EXT;
        end
      end
    endcase
  end

  // Reset start-up adds the extra cycles; deep-sleep wake does not
  assign osc_tgt = (st_r == ST_STAB) ? CW'(stab_tgt + extra_tgt) : stab_tgt;

  cssc_tick_counter #(
    .CNT_W(CW)
  ) u_wdt_cnt (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .tick_pin_i(WDT_OSC_I),
    .clear_i(st_r != ST_TOUT),
    .target_i(tout_tgt),
    .tick_o(),
    .done_o(wdt_done)
  );

  cssc_tick_counter #(
    .CNT_W(CW)
  ) u_osc_cnt (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .tick_pin_i(SEL_OSC_I),
    .clear_i((st_r != ST_STAB) && (st_r != ST_WAKE)),
    .target_i(osc_tgt),
    .tick_o(osc_tick),
    .done_o(osc_done)
  );

  always_comb begin
    st_nxt = st_r;
    src_sel_nxt = src_sel_r;
    stime_nxt = stime_r;
    div8_nxt = div8_r;
    latched_nxt = latched_r;
    fwait_nxt = fwait_r;
    mode_nxt = mode_r;
    irq_nxt = 1'b0;
    case (st_r)
      ST_FUSE: begin
        // Wait for the fuse synchronisers to fill, then sample once
        if (fwait_r == cssc_pkg::FUSE_WAIT_CYC) begin
          src_sel_nxt = src_sel_s;
          stime_nxt = stime_s;
          div8_nxt = div8_s;
          latched_nxt = 1'b1;
          st_nxt = ST_HOLD;
        end else begin
          fwait_nxt = fwait_r + 1'b1;
        end
      end
      ST_HOLD: begin
        if (!rst_src_s) begin
          st_nxt = ST_TOUT;
        end
      end
      ST_TOUT: begin
        if (wdt_done) begin
          st_nxt = ST_STAB;
        end
      end
      ST_STAB: begin
        if (osc_done) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (SLEEP_I) begin
          mode_nxt = cssc_pkg::cssc_sleep_t'(SLEEP_MODE_I);
          st_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_s) begin
          if (mode_r == cssc_pkg::SLP_PWR_DOWN ||
              mode_r == cssc_pkg::SLP_PWR_SAVE) begin
            st_nxt = ST_WAKE;
          end else begin
            st_nxt = ST_RUN;
          end
        end
      end
      ST_WAKE: begin
        if (osc_done) begin
          st_nxt = ST_RUN;
          // A level that dropped during start-up wakes but is not reported
          irq_nxt = level_s && (mode_r == cssc_pkg::SLP_PWR_DOWN);
        end
      end
      default: st_nxt = ST_HOLD;
    endcase
    // Any returning reset source restarts the full sequence, fuses kept
    if (rst_src_s && st_r != ST_FUSE) begin
      st_nxt = ST_HOLD;
      irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r <= ST_FUSE;
      src_sel_r <= cssc_pkg::FUSE_SRC_DFLT;
      stime_r <= cssc_pkg::FUSE_STIME_DFLT;
      div8_r <= cssc_pkg::FUSE_DIV8_DFLT;
      latched_r <= 1'b0;
      fwait_r <= 2'h0;
      mode_r <= cssc_pkg::SLP_IDLE;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      src_sel_r <= src_sel_nxt;
      stime_r <= stime_nxt;
      div8_r <= div8_nxt;
      latched_r <= latched_nxt;
      fwait_r <= fwait_nxt;
      mode_r <= mode_nxt;
      irq_r <= irq_nxt;
    end
  end

  // System clock prescaler on the selected oscillator
  logic [2:0] div_cnt_r;
  logic [2:0] div_cnt_nxt;
  logic sys_tick_r;
  logic sys_tick_nxt;
  logic div8_on;

  assign div8_on = ~div8_r;

  always_comb begin
    div_cnt_nxt = div_cnt_r;
    sys_tick_nxt = 1'b0;
    if (INTERNAL_RESET_O) begin
      div_cnt_nxt = cssc_pkg::DIV_ZERO;
    end else if (osc_tick) begin
      if (!div8_on || div_cnt_r == cssc_pkg::DIV8_LAST) begin
        div_cnt_nxt = cssc_pkg::DIV_ZERO;
        sys_tick_nxt = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_cnt_r <= 3'h0;
      sys_tick_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      sys_tick_r <= sys_tick_nxt;
    end
  end

  // Domain gating: each enable is decoded from registered state
  logic slp;
  assign slp = (st_r == ST_SLEEP);
  assign INTERNAL_RESET_O = (st_r == ST_FUSE) || (st_r == ST_HOLD) ||
                            (st_r == ST_TOUT) || (st_r == ST_STAB);
  assign CORE_CLOCK_EN_O = (st_r == ST_RUN);
  assign PROGRAM_MEMORY_CLOCK_EN_O = CORE_CLOCK_EN_O;
  assign PERIPHERAL_CLOCK_EN_O = (st_r == ST_RUN) ||
                                 (slp && mode_r == cssc_pkg::SLP_IDLE);
  assign CONVERTER_CLOCK_EN_O = (st_r == ST_RUN) ||
    (slp && (mode_r == cssc_pkg::SLP_IDLE ||
             mode_r == cssc_pkg::SLP_ADC_NR));
  // Power-down stops the timer domain too; every other sleep keeps it
  assign ASYNC_TIMER_CLOCK_EN_O = !INTERNAL_RESET_O &&
    !(slp && mode_r == cssc_pkg::SLP_PWR_DOWN);
  assign ASYNC_DETECT_EN_O = slp && !PERIPHERAL_CLOCK_EN_O;
  assign SYS_CLK_TICK_O = sys_tick_r;
  assign CLK_SOURCE_O = src;
  assign AMP_RANGE_O = (src == cssc_pkg::SRC_LP_XTAL) ?
                       src_sel_r[3:1] : 3'h0;
  assign DIV8_ACTIVE_O = div8_on;
  assign FUSE_RESERVED_O = (src_sel_r == cssc_pkg::SRC_SEL_RESERVED);
  assign LEVEL_IRQ_O = irq_r;

  fuse_hold_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    latched_r |=> $stable(src_sel_r) && $stable(stime_r) && $stable(div8_r))
    else $error("latched fuses changed");

  resv_fallback_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    src_sel_r == cssc_pkg::SRC_SEL_RESERVED |-> src == cssc_pkg::SRC_RC_CAL)
    else $error("reserved code did not fall back");

  tout_stab_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    st_r == ST_TOUT && wdt_done && !rst_src_s |=> st_r == ST_STAB)
    else $error("time-out end did not start stabilisation");

  wake_skip_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    st_r == ST_WAKE |=> st_r != ST_TOUT && st_r != ST_STAB)
    else $error("wake ran the supply time-out");

  stab_hold_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    st_r == ST_STAB && !osc_done |=> INTERNAL_RESET_O)
    else $error("reset released before stabilisation");

  core_gate_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    slp |-> !CORE_CLOCK_EN_O && !PROGRAM_MEMORY_CLOCK_EN_O)
    else $error("core clock running in sleep");

  adc_run_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    slp && mode_r == cssc_pkg::SLP_ADC_NR |->
      CONVERTER_CLOCK_EN_O && !PERIPHERAL_CLOCK_EN_O && ASYNC_DETECT_EN_O)
    else $error("converter domain gating wrong");

  level_irq_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    LEVEL_IRQ_O |-> $past(level_s) && $past(st_r) == ST_WAKE &&
      st_r == ST_RUN)
    else $error("level interrupt without held level");

  lp_tout_a: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    src == cssc_pkg::SRC_LP_XTAL && code == 3'h5 |->
      tout_tgt == cssc_pkg::TOUT_NONE && stab_tgt == STAB_16K_CYC)
    else $error("low-power crystal code decode wrong");

endmodule // cssc_top
